//--- failsafe_consts.svh
// Offsets, field positions, reset values, command codes and counts
`ifndef FAILSAFE_CONSTS_SVH
`define FAILSAFE_CONSTS_SVH

// Register byte addresses
`define OFF_CTRL        8'h00
`define OFF_SECURE_POSITION      8'h04
`define OFF_NODE_ADDR   8'h08
`define OFF_STATUS      8'h0C
`define OFF_IGNORED     8'h10
`define OFF_TARGET      8'h14

// Control fields
`define CTRL_LOWPOWER   0
`define CTRL_AUTOREF    1
`define CTRL_SHAFT      2
`define CTRL_RESET      3'h0
`define SECURE_POSITION_RESET    11'h400
`define SECURE_POSITION_NONE     11'h400
`define NODE_RESET      7'h00

// Bus-loss time-out in frame slots
`define LOST_SLOTS      15'h61A8

// Position scaling, 16-bit position in sixteenth steps
`define SECURE_POSITION_SHIFT    5
`define SHORT_SHIFT     3
`define HALF_RANGE      16'h8000
`define CONFIRM_MOVE    16'hFF60

// Command codes
`define C_RD_POS        7'h00
`define C_RD_FULL       7'h01
`define C_RD_OTP        7'h02
`define C_RD_SHORT      7'h03
`define C_GO_SAFE       7'h04
`define C_HALT_NOW      7'h05
`define C_ZERO_POS      7'h06
`define C_TWO_STAGE     7'h08
`define C_MOTION_PARAM  7'h09
`define C_MOVE_TO       7'h0B
`define C_SHORT_1       7'h0C
`define C_SHORT_2       7'h0D
`define C_SHORT_4       7'h0E
`define C_HALT_DECEL    7'h0F
`define C_OTP_BYTE      7'h10
`define C_STALL_PARAM   7'h16
`define C_MOVE_PARAM    7'h2F

`endif

//--- failsafe_pkg.sv
// Types shared by the fail-safe and command decode block
package failsafe_pkg;
	typedef enum logic [3:0] {
		ST_RUN,
		ST_SECURE,
		ST_SECURE_WAIT,
		ST_REF_SEEK,
		ST_REF_STALL,
		ST_CONFIRM,
		ST_CONFIRM_WAIT,
		ST_FINISH,
		ST_STOP,
		ST_SLEEP
	} fs_state_t;
endpackage : failsafe_pkg

//--- watchdog_if.sv
// Carrier between the decoder and the bus-loss watchdog
`timescale 1ns/1ps
interface watchdog_if;
	logic slot_tick;
	logic activity;
	logic bus_lost;
	modport ctl (output slot_tick, output activity, input bus_lost);
	modport dog (input slot_tick, input activity, output bus_lost);
endinterface : watchdog_if

//--- bus_loss_watchdog.sv
// Counts empty frame slots and raises the bus-lost flag
`timescale 1ns/1ps
`include "failsafe_consts.svh"
module bus_loss_watchdog (
	input  wire logic pclk,
	input  wire logic presetn,
	watchdog_if.dog   wd
);
	logic [14:0] slots_q;
	logic        lost_q;

	assign wd.bus_lost = lost_q;

	// Activity wins over a tick in the same cycle, so a live bus never
	// times out on a coincident slot boundary
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slots_q <= 15'h0000;
			lost_q  <= 1'b0;
		end else if (wd.activity) begin
			slots_q <= 15'h0000;
			lost_q  <= 1'b0;
		end else if (wd.slot_tick && !lost_q) begin
			if (slots_q == `LOST_SLOTS - 15'h0001)
				lost_q <= 1'b1;
			else
				slots_q <= slots_q + 15'h0001;
		end
	end
endmodule : bus_loss_watchdog

//--- bus_loss_failsafe_and_command_decode.sv
// Command decode and bus-loss fail-safe sequencer with APB registers
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "failsafe_consts.svh"
module bus_loss_failsafe_and_command_decode
	import failsafe_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        frame_slot_tick,
	input  wire logic        frame_activity,
	input  wire logic        hardwired_address_input,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_sleep,
	input  wire logic [6:0]  cmd_code,
	input  wire logic [3:0]  cmd_frame_type,
	input  wire logic        cmd_broad,
	input  wire logic [6:0]  cmd_addr,
	input  wire logic [15:0] cmd_data,
	input  wire logic        motion_done,
	input  wire logic        stall_hit,
	output logic             motion_start,
	output logic             motion_relative,
	output logic             motion_use_otp,
	output logic             motion_until_stall,
	output logic      [15:0] target_position,
	output logic             halt_immediate,
	output logic             halt_decel,
	output logic             position_zero,
	output logic             param_write,
	output logic      [6:0]  param_code,
	output logic      [15:0] param_data,
	output logic             read_req,
	output logic      [6:0]  read_sel,
	output logic             sleep_state,
	output logic             stop_state
);
	// Secure units to sixteenth steps, two full steps per unit
	function automatic logic [15:0] secure_to_pos(input logic [10:0] s);
		secure_to_pos = {s, 5'b0_0000};
	endfunction : secure_to_pos

	// Legal code and frame type pairs; anything else is dropped
	function automatic logic cmd_legal(input logic [6:0] c,
		input logic [3:0] t);
		case (c)
			`C_RD_POS:       cmd_legal = (t == 4'h5) || (t == 4'h6)
				|| (t == 4'h7) || (t == 4'h8);
			`C_RD_FULL,
			`C_RD_OTP:       cmd_legal = (t == 4'h7) || (t == 4'h8);
			`C_RD_SHORT:     cmd_legal = (t == 4'h5);
			`C_GO_SAFE,
			`C_HALT_NOW,
			`C_ZERO_POS,
			`C_HALT_DECEL:   cmd_legal = (t == 4'h1);
			`C_TWO_STAGE,
			`C_MOTION_PARAM,
			`C_OTP_BYTE,
			`C_STALL_PARAM:  cmd_legal = (t == 4'h4);
			`C_MOVE_TO:      cmd_legal = (t == 4'h1) || (t == 4'h3)
				|| (t == 4'h4);
			`C_SHORT_1,
			`C_SHORT_2,
			`C_SHORT_4,
			`C_MOVE_PARAM:   cmd_legal = (t == 4'h2);
			default:         cmd_legal = 1'b0;
		endcase
	endfunction : cmd_legal

	fs_state_t   state_q, state_d;
	logic [2:0]  ctrl_q, ctrl_d;
	logic [10:0] secure_position_q, secure_position_d;
	logic [6:0]  node_q;
	logic [15:0] ignored_q, ignored_d;
	logic        referenced_q, referenced_d;
	logic        startup_q;
	logic        lost_src_q;
	logic        float_trig_q, float_trig_d;
	logic        start_d, rel_d, otp_d, stall_d;
	logic [15:0] tgt_d;
	logic        hard_d, soft_d, zero_d, pw_d, rreq_d;
	logic [6:0]  pcode_d, rsel_d;
	logic [15:0] pdata_d;

	watchdog_if wd ();

	bus_loss_watchdog u_watchdog (
		.pclk    (pclk),
		.presetn (presetn),
		.wd      (wd)
	);

	assign wd.slot_tick = frame_slot_tick;
	assign wd.activity  = frame_activity;

	// APB decode; answer comes one cycle into the access phase
	wire        apb_access = psel && penable && !pready;
	wire        apb_write  = psel && penable && pready && pwrite;
	wire        addr_hit   = (paddr == `OFF_CTRL) || (paddr == `OFF_SECURE_POSITION)
		|| (paddr == `OFF_NODE_ADDR) || (paddr == `OFF_STATUS)
		|| (paddr == `OFF_IGNORED) || (paddr == `OFF_TARGET);
	wire        wr_ctrl    = apb_write && (paddr == `OFF_CTRL);
	wire        wr_secure_position  = apb_write && (paddr == `OFF_SECURE_POSITION);
	wire        wr_node    = apb_write && (paddr == `OFF_NODE_ADDR);
	wire [31:0] rd_mux     =
		(paddr == `OFF_CTRL)      ? {29'h0000_0000, ctrl_q} :
		(paddr == `OFF_SECURE_POSITION)    ? {21'h00_0000, secure_position_q} :
		(paddr == `OFF_NODE_ADDR) ? {25'h000_0000, node_q} :
		(paddr == `OFF_STATUS)    ? {25'h000_0000, state_q,
			startup_q, referenced_q, wd.bus_lost} :
		(paddr == `OFF_IGNORED)   ? {16'h0000, ignored_q} :
		(paddr == `OFF_TARGET)    ? {16'h0000, target_position} :
		32'h0000_0000;

	// Configuration fields
	wire lowpower_en = ctrl_q[`CTRL_LOWPOWER];
	wire autoref_en  = ctrl_q[`CTRL_AUTOREF];
	wire shaft_bit   = ctrl_q[`CTRL_SHAFT];

	// floating address counts as a loss
	wire lost_src    = wd.bus_lost || hardwired_address_input;
	wire fs_trigger  = lost_src && !lost_src_q && (state_q == ST_RUN);
	wire secure_none = (secure_position_q == `SECURE_POSITION_NONE);

	// broadcast at zero ignores the address
	wire addr_ok     = !cmd_broad || (cmd_addr == node_q);
	wire cmd_take    = cmd_valid && !cmd_sleep && addr_ok
		&& cmd_legal(cmd_code, cmd_frame_type);
	wire cmd_drop    = cmd_valid && !cmd_sleep && addr_ok && !cmd_take;
	wire [15:0] short_pos = {{2{cmd_data[10]}}, cmd_data[10:0], 3'b000};

	// Sequencer and command dispatch; commands override the sequence
	always_comb begin
		state_d      = state_q;
		ctrl_d       = wr_ctrl ? pwdata[2:0] : ctrl_q;
		secure_position_d     = wr_secure_position ? pwdata[10:0] : secure_position_q;
		ignored_d    = cmd_drop ? ignored_q + 16'h0001 : ignored_q;
		referenced_d = referenced_q;
		float_trig_d = float_trig_q;
		start_d      = 1'b0;
		rel_d        = motion_relative;
		otp_d        = motion_use_otp;
		stall_d      = motion_until_stall;
		tgt_d        = target_position;
		hard_d       = 1'b0;
		soft_d       = 1'b0;
		zero_d       = 1'b0;
		pw_d         = 1'b0;
		pcode_d      = param_code;
		pdata_d      = param_data;
		rreq_d       = 1'b0;
		rsel_d       = read_sel;
		case (state_q)
			ST_RUN: begin
				if (fs_trigger) begin
					float_trig_d = !wd.bus_lost;
					if (referenced_q && !startup_q)
						state_d = ST_SECURE;
					else if (autoref_en)
						state_d = ST_REF_SEEK;
					else
						state_d = ST_SECURE;
				end
			end
			ST_REF_SEEK: begin
				start_d = 1'b1;
				rel_d   = 1'b1;
				otp_d   = 1'b1;
				stall_d = 1'b1;
				tgt_d   = `HALF_RANGE;
				if (startup_q && shaft_bit)
					tgt_d = 16'h7FFF;
				state_d = ST_REF_STALL;
			end
			ST_REF_STALL: begin
				if (stall_hit) begin
					zero_d       = 1'b1;
					referenced_d = 1'b1;
					state_d      = ST_CONFIRM;
				end
			end
			ST_CONFIRM: begin
				start_d = 1'b1;
				rel_d   = 1'b1;
				otp_d   = 1'b1;
				stall_d = 1'b0;
				tgt_d   = `CONFIRM_MOVE;
				state_d = ST_CONFIRM_WAIT;
			end
			ST_CONFIRM_WAIT: begin
				if (motion_done)
					state_d = ST_SECURE;
			end
			ST_SECURE: begin
				if (secure_none) begin
					state_d = ST_FINISH;
				end else begin
					start_d = 1'b1;
					rel_d   = 1'b0;
					otp_d   = 1'b0;
					stall_d = 1'b0;
					tgt_d   = secure_to_pos(secure_position_q);
					state_d = ST_SECURE_WAIT;
				end
			end
			ST_SECURE_WAIT: begin
				if (motion_done)
					state_d = ST_FINISH;
			end
			ST_FINISH: begin
				if (lowpower_en && !(float_trig_q && !wd.bus_lost))
					state_d = ST_SLEEP;
				else
					state_d = ST_STOP;
			end
			ST_STOP, ST_SLEEP: begin
				state_d = state_q;
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
		if (cmd_valid && cmd_sleep)
			state_d = lowpower_en ? ST_SLEEP : ST_STOP;
		if (cmd_take) begin
			state_d = ST_RUN;
			start_d = 1'b0;
			zero_d  = 1'b0;
			case (cmd_code)
				`C_RD_POS, `C_RD_FULL, `C_RD_OTP, `C_RD_SHORT: begin
					rreq_d = 1'b1;
					rsel_d = cmd_code;
				end
				`C_GO_SAFE: begin
					start_d = !secure_none;
					rel_d   = 1'b0;
					otp_d   = 1'b0;
					stall_d = 1'b0;
					tgt_d   = secure_to_pos(secure_position_q);
				end
				`C_HALT_NOW: begin
					hard_d = 1'b1;
				end
				`C_HALT_DECEL: begin
					soft_d = 1'b1;
				end
				`C_ZERO_POS: begin
					zero_d       = 1'b1;
					referenced_d = 1'b1;
				end
				`C_TWO_STAGE, `C_OTP_BYTE, `C_STALL_PARAM: begin
					pw_d         = 1'b1;
					pcode_d      = cmd_code;
					pdata_d      = cmd_data;
					referenced_d = referenced_q
						|| (cmd_code == `C_TWO_STAGE);
				end
				`C_MOTION_PARAM: begin
					// Master may rewrite the secure position here
					pw_d     = 1'b1;
					pcode_d  = cmd_code;
					pdata_d  = cmd_data;
					secure_position_d = cmd_data[10:0];
				end
				`C_MOVE_TO, `C_SHORT_1, `C_SHORT_2, `C_SHORT_4: begin
					start_d = 1'b1;
					rel_d   = 1'b0;
					otp_d   = 1'b0;
					stall_d = 1'b0;
					tgt_d   = (cmd_code == `C_MOVE_TO) ? cmd_data
						: short_pos;
				end
				`C_MOVE_PARAM: begin
					start_d = 1'b1;
					rel_d   = 1'b0;
					otp_d   = 1'b0;
					stall_d = 1'b0;
					tgt_d   = short_pos;
					pw_d    = 1'b1;
					pcode_d = cmd_code;
					pdata_d = cmd_data;
				end
				default: begin
					state_d = ST_RUN;
				end
			endcase
		end
	end

	// Sequencer and status state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q      <= ST_RUN;
			referenced_q <= 1'b0;
			startup_q    <= 1'b1;
			lost_src_q   <= 1'b0;
			float_trig_q <= 1'b0;
			ignored_q    <= 16'h0000;
		end else begin
			state_q      <= state_d;
			referenced_q <= referenced_d;
			// Power-on window closes on first bus traffic
			startup_q    <= startup_q && !frame_activity;
			lost_src_q   <= lost_src;
			float_trig_q <= float_trig_d;
			ignored_q    <= ignored_d;
		end
	end

	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q   <= `CTRL_RESET;
			secure_position_q <= `SECURE_POSITION_RESET;
			node_q   <= `NODE_RESET;
		end else begin
			ctrl_q   <= ctrl_d;
			secure_position_q <= secure_position_d;
			if (wr_node)
				node_q <= pwdata[6:0];
		end
	end

	// Registered APB answer: one wait cycle keeps prdata a flop output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= apb_access;
			pslverr <= apb_access && !addr_hit;
			if (apb_access)
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
		end
	end

	// Motion and dispatch outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			motion_start       <= 1'b0;
			motion_relative    <= 1'b0;
			motion_use_otp     <= 1'b0;
			motion_until_stall <= 1'b0;
			target_position    <= 16'h0000;
			halt_immediate     <= 1'b0;
			halt_decel         <= 1'b0;
			position_zero      <= 1'b0;
			param_write        <= 1'b0;
			param_code         <= 7'h00;
			param_data         <= 16'h0000;
			read_req           <= 1'b0;
			read_sel           <= 7'h00;
			sleep_state        <= 1'b0;
			stop_state         <= 1'b0;
		end else begin
			motion_start       <= start_d;
			motion_relative    <= rel_d;
			motion_use_otp     <= otp_d;
			motion_until_stall <= stall_d;
			target_position    <= tgt_d;
			halt_immediate     <= hard_d;
			halt_decel         <= soft_d;
			position_zero      <= zero_d;
			param_write        <= pw_d;
			param_code         <= pcode_d;
			param_data         <= pdata_d;
			read_req           <= rreq_d;
			read_sel           <= rsel_d;
			sleep_state        <= (state_d == ST_SLEEP);
			stop_state         <= (state_d == ST_STOP);
		end
	end
endmodule : bus_loss_failsafe_and_command_decode

//--- failsafe_assertions.sv
// Concurrent checks on the decode and fail-safe outputs
`timescale 1ns/1ps
module failsafe_assertions (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        cmd_valid,
	input wire logic        cmd_sleep,
	input wire logic [6:0]  cmd_code,
	input wire logic [3:0]  cmd_frame_type,
	input wire logic        cmd_broad,
	input wire logic [15:0] cmd_data,
	input wire logic        stall_hit,
	input wire logic        motion_start,
	input wire logic        motion_relative,
	input wire logic        motion_use_otp,
	input wire logic        motion_until_stall,
	input wire logic [15:0] target_position,
	input wire logic        halt_immediate,
	input wire logic        halt_decel,
	input wire logic        position_zero,
	input wire logic        read_req,
	input wire logic [6:0]  read_sel,
	input wire logic        sleep_state,
	input wire logic        stop_state
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Broadcast command frames and legal code/type pairs of read codes 00 and 03
	wire take = cmd_valid && !cmd_broad && !cmd_sleep;
	wire rd_ok = (cmd_code == 7'h00 && cmd_frame_type >= 4'h5 &&
		cmd_frame_type <= 4'h8) || (cmd_code == 7'h03 && cmd_frame_type == 4'h5);
	wire any_out = motion_start || halt_immediate || halt_decel ||
		position_zero || read_req;
	property p_move_to;
		take && cmd_code == 7'h0B && cmd_frame_type == 4'h1 |=> motion_start
			&& !motion_relative && target_position == $past(cmd_data);
	endproperty
	a_move_to: assert property (p_move_to)
		else $error("move command gave no absolute move");
	property p_halt_now;
		take && cmd_code == 7'h05 && cmd_frame_type == 4'h1 |=> halt_immediate;
	endproperty
	a_halt_now: assert property (p_halt_now)
		else $error("immediate halt missing");
	property p_halt_decel;
		take && cmd_code == 7'h0F && cmd_frame_type == 4'h1
			|=> halt_decel && !halt_immediate;
	endproperty
	a_halt_decel: assert property (p_halt_decel)
		else $error("decelerating halt missing");
	property p_read;
		take && rd_ok |=> read_req && read_sel == $past(cmd_code);
	endproperty
	a_read: assert property (p_read)
		else $error("read request wrong");
	property p_unknown;
		take && cmd_code == 7'h07 |=> !any_out [*2];
	endproperty
	a_unknown: assert property (p_unknown)
		else $error("unknown code had an effect");
	property p_zero;
		stall_hit && motion_until_stall |=> position_zero;
	endproperty
	a_zero: assert property (p_zero)
		else $error("stall did not zero position");
	sequence s_confirm;
		motion_start && motion_relative && target_position == 16'hFF60;
	endsequence
	property p_confirm;
		stall_hit && motion_until_stall |=> ##[1:4] s_confirm;
	endproperty
	a_confirm: assert property (p_confirm)
		else $error("confirm move missing");
	property p_seek;
		motion_start && motion_until_stall |-> motion_relative && motion_use_otp;
	endproperty
	a_seek: assert property (p_seek)
		else $error("seek move not relative with stored parameters");
	// Both state flags are registered from the next state, so one of
	// them already stands in the cycle after the sleep frame
	property p_sleep_cmd;
		cmd_valid && cmd_sleep && !cmd_broad
			|=> (sleep_state || stop_state);
	endproperty
	a_sleep_cmd: assert property (p_sleep_cmd)
		else $error("sleep frame did not stop the block");
	property p_one_state;
		!(sleep_state && stop_state);
	endproperty
	a_one_state: assert property (p_one_state)
		else $error("sleep and stop both set");
	// Main scenarios reached
	c_seek: cover property (motion_start && motion_until_stall);
	c_sleep: cover property ($rose(sleep_state));
	c_stall: cover property (stall_hit ##1 position_zero);
endmodule : failsafe_assertions

//--- lin_master_model.sv
// Bus master and motion engine model facing the block
`timescale 1ns/1ps
module lin_master_model (
	input wire logic        pclk,
	input wire logic        motion_start,
	input wire logic        motion_relative,
	input wire logic        motion_until_stall,
	input wire logic [15:0] target_position,
	output logic            frame_slot_tick,
	output logic            frame_activity,
	output logic            cmd_valid,
	output logic            cmd_sleep,
	output logic [6:0]      cmd_code,
	output logic [3:0]      cmd_frame_type,
	output logic            cmd_broad,
	output logic [6:0]      cmd_addr,
	output logic [15:0]     cmd_data,
	output logic            motion_done,
	output logic            stall_hit
);
	logic [17:0] moves[$];
	logic [5:0]  wait_q = 6'h0;
	logic        stall_q = 1'b0;
	logic        slow_q = 1'b0;
	// Idle bus and motor at time zero
	initial begin
		{frame_slot_tick, frame_activity, cmd_valid, cmd_sleep} = 4'h0;
		{cmd_code, cmd_frame_type, cmd_broad, cmd_addr} = 19'h0;
		cmd_data = 16'h0000;
	end
	// Moves end alternately fast and slow, at stall when asked
	always @(posedge pclk) begin
		motion_done <= 1'b0;
		stall_hit <= 1'b0;
		if (motion_start) begin
			moves.push_back({motion_relative, motion_until_stall, target_position});
			wait_q <= slow_q ? 6'h1E : 6'h2;
			stall_q <= motion_until_stall;
			slow_q <= !slow_q;
		end else if (wait_q == 6'h1) begin
			stall_hit <= stall_q;
			motion_done <= !stall_q;
			wait_q <= 6'h0;
		end else if (wait_q != 6'h0)
			wait_q <= wait_q - 6'h1;
	end
	task send_cmd(input logic [6:0] c, input logic [3:0] t,
		input logic b, input logic [6:0] a, input logic s);
		@(posedge pclk);
		{cmd_valid, cmd_sleep, cmd_code, cmd_frame_type} <= {1'b1, s, c, t};
		{cmd_broad, cmd_addr, cmd_data} <= {b, a, 16'h0405};
		@(posedge pclk);
		{cmd_valid, cmd_sleep} <= 2'h0;
	endtask : send_cmd
	// Empty frame slots, one per cycle
	task ticks(input int n);
		repeat (n) begin
			@(posedge pclk);
			frame_slot_tick <= 1'b1;
		end
		@(posedge pclk);
		frame_slot_tick <= 1'b0;
	endtask : ticks
	task activity;
		@(posedge pclk);
		frame_activity <= 1'b1;
		@(posedge pclk);
		frame_activity <= 1'b0;
	endtask : activity
endmodule : lin_master_model

//--- bus_loss_failsafe_and_command_decode_test.sv
// Self-checking bench for the fail-safe and command decode block
`timescale 1ns/1ps
module bus_loss_failsafe_and_command_decode_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, ign;
	logic hardwired_address_input = 0, rerr, pready, pslverr;
	logic frame_slot_tick, frame_activity, cmd_valid, cmd_sleep, cmd_broad;
	logic [6:0] cmd_code, cmd_addr, param_code, read_sel;
	logic [3:0] cmd_frame_type;
	logic [15:0] cmd_data, target_position, param_data;
	logic motion_done, stall_hit, motion_start, motion_relative;
	logic motion_use_otp, motion_until_stall, halt_immediate, halt_decel;
	logic position_zero, param_write, read_req, sleep_state, stop_state;
	int num_errors = 0, checks_done = 0;
	bus_loss_failsafe_and_command_decode bus_loss_failsafe_and_command_decode_i (.*);
	lin_master_model lin_master_model_i (.*);
	// 40 MHz clock
	always #12.5 pclk = ~pclk;
	task stop_test;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// One APB transfer, held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// No fixed wait count; only the hang guard ends a stuck transfer
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		rerr = pslverr;
		{psel, penable} <= 2'h0;
	endtask : apb
	task rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, rd, e);
	endtask : rd_chk
	task state_chk(input logic [3:0] e);
		apb(1'b0, 8'h0C, 32'h0);
		chk("state", 32'(rd[6:3]), 32'(e));
	endtask : state_chk
	// Send a frame and collect the output pulses that follow
	task cmd(input logic [6:0] c, input logic [3:0] t, input logic b,
		input logic [6:0] a, input logic [5:0] e, input logic [5:0] m,
		input logic [31:0] inc);
		logic [5:0] seen;
		seen = 6'h0;
		lin_master_model_i.send_cmd(c, t, b, a, 1'b0);
		repeat (3) begin
			@(posedge pclk);
			seen |= {read_req, motion_start, halt_immediate, halt_decel,
				position_zero, param_write};
		end
		ign = ign + inc;
		chk("pulses", 32'(seen & m), 32'(e));
		rd_chk("ignored", 8'h10, ign);
	endtask : cmd
	task sleep_frame;
		lin_master_model_i.send_cmd(7'h00, 4'h1, 1'b0, 7'h00, 1'b1);
	endtask : sleep_frame
	task wait_end;
		int n;
		n = 0;
		while (stop_state !== 1'b1 && sleep_state !== 1'b1 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		// A sequence that never ends counts as a mismatch
		if (n == 3000)
			num_errors++;
		repeat (2) @(posedge pclk);
	endtask : wait_end
	task move(input logic [17:0] e);
		logic [17:0] m;
		m = lin_master_model_i.moves.size() ? lin_master_model_i.moves.pop_front() : 18'h0;
		chk("move", 32'(m), 32'(e));
	endtask : move
	task float_pin(input logic f);
		@(posedge pclk);
		hardwired_address_input <= f;
	endtask : float_pin
	task do_reset;
		presetn <= 1'b0;
		ign = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
	endtask : do_reset
	// Hang guard, well beyond the expected run
	initial begin
		repeat (60000) @(posedge pclk);
		num_errors++;
		stop_test;
	end
	// Main sequence
	initial begin
		do_reset;
		rd_chk("ctrl", 8'h00, 32'h0);
		rd_chk("secure", 8'h04, 32'h400);
		rd_chk("status", 8'h0C, 32'h4);
		apb(1'b0, 8'h18, 32'h0);
		chk("slverr", 32'(rerr), 32'h1);
		apb(1'b1, 8'h08, 32'h5);
		apb(1'b1, 8'h04, 32'h10);
		cmd(7'h00, 4'h5, 0, 0, 6'h20, 6'h3F, 0);
		cmd(7'h01, 4'h7, 0, 0, 6'h20, 6'h3F, 0);
		cmd(7'h02, 4'h8, 0, 0, 6'h20, 6'h3F, 0);
		cmd(7'h03, 4'h5, 0, 0, 6'h20, 6'h3F, 0);
		cmd(7'h04, 4'h1, 0, 0, 6'h10, 6'h3F, 0);
		chk("target", 32'(target_position), 32'h200);
		cmd(7'h05, 4'h1, 0, 0, 6'h08, 6'h3F, 0);
		cmd(7'h06, 4'h1, 0, 0, 6'h02, 6'h3F, 0);
		cmd(7'h0F, 4'h1, 0, 0, 6'h04, 6'h3F, 0);
		cmd(7'h08, 4'h4, 0, 0, 6'h01, 6'h3F, 0);
		cmd(7'h09, 4'h4, 0, 0, 6'h01, 6'h3F, 0);
		rd_chk("secure", 8'h04, 32'h405);
		cmd(7'h10, 4'h4, 0, 0, 6'h01, 6'h3F, 0);
		cmd(7'h16, 4'h4, 0, 0, 6'h01, 6'h3F, 0);
		chk("param", 32'({param_code, param_data}), 32'h0016_0405);
		cmd(7'h0B, 4'h1, 0, 0, 6'h10, 6'h3F, 0);
		chk("target", 32'(target_position), 32'h405);
		cmd(7'h0B, 4'h3, 0, 0, 6'h10, 6'h3F, 0);
		cmd(7'h0B, 4'h4, 0, 0, 6'h10, 6'h3F, 0);
		cmd(7'h0D, 4'h2, 0, 0, 6'h10, 6'h3F, 0);
		cmd(7'h0C, 4'h2, 0, 0, 6'h10, 6'h3F, 0);
		chk("target", 32'(target_position), 32'hE028);
		cmd(7'h0E, 4'h2, 0, 0, 6'h10, 6'h3F, 0);
		cmd(7'h2F, 4'h2, 0, 0, 6'h11, 6'h3F, 0);
		cmd(7'h05, 4'h1, 1, 5, 6'h08, 6'h3F, 0);
		cmd(7'h05, 4'h1, 1, 6, 6'h00, 6'h3F, 0);
		cmd(7'h0B, 4'h2, 0, 0, 6'h00, 6'h3F, 1);
		cmd(7'h07, 4'h1, 0, 0, 6'h00, 6'h3F, 1);
		sleep_frame;
		wait_end;
		chk("stop", 32'(stop_state), 32'h1);
		cmd(7'h05, 4'h1, 0, 0, 6'h08, 6'h3F, 0);
		apb(1'b1, 8'h00, 32'h1);
		sleep_frame;
		wait_end;
		chk("sleep", 32'(sleep_state), 32'h1);
		cmd(7'h05, 4'h1, 0, 0, 6'h08, 6'h3F, 0);
		// Power-on loss, seek with shaft set, secure move skipped
		apb(1'b1, 8'h04, 32'h400);
		apb(1'b1, 8'h00, 32'h6);
		lin_master_model_i.moves.delete();
		float_pin(1'b1);
		wait_end;
		move(18'h3_7FFF);
		move(18'h2_FF60);
		chk("extra", lin_master_model_i.moves.size(), 0);
		state_chk(4'h8);
		float_pin(1'b0);
		lin_master_model_i.activity;
		cmd(7'h06, 4'h1, 0, 0, 6'h02, 6'h3F, 0);
		// Referenced, floating pin while bus is alive: no sleep
		apb(1'b1, 8'h00, 32'h3);
		apb(1'b1, 8'h04, 32'h123);
		float_pin(1'b1);
		wait_end;
		move(18'h0_2460);
		chk("stop", 32'(stop_state), 32'h1);
		chk("sleep", 32'(sleep_state), 32'h0);
		float_pin(1'b0);
		cmd(7'h05, 4'h1, 0, 0, 6'h08, 6'h3F, 0);
		// Bus silent for the full time-out count
		lin_master_model_i.ticks(24999);
		apb(1'b0, 8'h0C, 32'h0);
		chk("lost", 32'(rd[0]), 32'h0);
		lin_master_model_i.ticks(1);
		wait_end;
		move(18'h0_2460);
		chk("sleep", 32'(sleep_state), 32'h1);
		apb(1'b0, 8'h0C, 32'h0);
		chk("lost", 32'(rd[0]), 32'h1);
		// Second reset: power-on loss without autonomous referencing
		do_reset;
		apb(1'b1, 8'h04, 32'h55);
		float_pin(1'b1);
		wait_end;
		move(18'h0_0AA0);
		state_chk(4'h8);
		float_pin(1'b0);
		lin_master_model_i.activity;
		cmd(7'h05, 4'h1, 0, 0, 6'h08, 6'h3F, 0);
		// Unreferenced in operation: full referencing run
		apb(1'b1, 8'h00, 32'h6);
		float_pin(1'b1);
		wait_end;
		move(18'h3_8000);
		move(18'h2_FF60);
		move(18'h0_0AA0);
		state_chk(4'h8);
		stop_test;
	end
endmodule : bus_loss_failsafe_and_command_decode_test
bind bus_loss_failsafe_and_command_decode failsafe_assertions failsafe_assertions_i (.*);
